// >>> hdl/sar_adc_serial_readout.sv
// Conversion control and serial result readout of a sampling converter
`timescale 1ns/100ps

// Contract
// - Conversion starts when the OR of select and read_convert_n falls.
// - busy_n low at start, high once result stored; acquisition follows.
// - Shifted word is always the last completed result.
// - Result goes out MSB first, format set by format_sel.
// - format_sel high gives straight binary, low gives two's complement.
// - First conversion after power-up is invalid; consumers drop it.
// - clock_source_sel low drives shift_clock; high takes host shift_clock.
// - Internal mode: 16 shift_clock pulses after the start delay carry the word.
// - Internal shift_clock rests low; bit valid over rising then falling edge.
// - After the last bit, data shows cascade_in as sampled at transfer start.
// - Internal mode sends every conversion regardless of select levels, unless the next one starts on the first cycle busy_n is high.
// - External mode: select and read_convert_n open the read state.
// - External mode bit valid falling then rising edge; host clock at most 28.5MHz.
// - Any rising edge outside read state makes a marker on first read edge.
// - Idle clock: no marker, first rising edge shows MSB.
// - cascade_in bits pass to data with host clock; not in internal mode.
// - One null bit, cascade_in at read start, separates own and forwarded words.
module sar_adc_serial_readout
   import sar_readout_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic select_n_i,
   input wire logic read_convert_n_i,
   input wire logic clock_source_sel_i,
   input wire logic format_sel_i,
   input wire logic cascade_in_i,
   input wire logic shift_clock_i,
   input wire logic [DATA_W-1:0] sar_result_i,
   output logic busy_n_o,
   output logic data_o,
   output logic frame_marker_o,
   output logic shift_clock_o,
   output logic shift_clock_oe_o,
   output logic result_valid_o
);

   readout_state_t s_q;
   readout_state_t s_d;

   logic sel_n;
   logic rc_n;
   logic src_ext;
   logic fmt_sb;
   logic casc;
   logic sclk;
   logic start_n;
   logic start_evt;
   logic read_cmd;
   logic sclk_rise;
   logic [DATA_W-1:0] fmt_word;

   // ****************************************************************
   // Synchronised pins and decoded events
   // ****************************************************************
   assign sel_n = s_q.sync2[PIN_SEL];
   assign rc_n = s_q.sync2[PIN_RC];
   assign src_ext = s_q.sync2[PIN_SRC];
   assign fmt_sb = s_q.sync2[PIN_FMT];
   assign casc = s_q.sync2[PIN_CASC];
   assign sclk = s_q.sync2[PIN_SCLK];
   assign start_n = sel_n | rc_n;
   assign start_evt = s_q.start_n_prev & ~start_n & s_q.busy_n;
   assign read_cmd = ~sel_n & rc_n;
   assign sclk_rise = ~s_q.sclk_prev & sclk;
   // Core delivers straight binary; flip sign bit for two's complement
   assign fmt_word = fmt_sb ? s_q.storage : {~s_q.storage[DATA_W-1], s_q.storage[DATA_W-2:0]};

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      s_d = s_q;
      s_d.sync1 = {shift_clock_i, cascade_in_i, format_sel_i, clock_source_sel_i,
                   read_convert_n_i, select_n_i};
      s_d.sync2 = s_q.sync1;
      s_d.start_n_prev = start_n;
      s_d.sclk_prev = sclk;
      s_d.read_prev = read_cmd;
      s_d.sclk_oe = ~src_ext;

      // Conversion timing and storage load
      if (start_evt)
      begin
         s_d.busy_n = 1'b0;
         s_d.conv_cnt = '0;
      end
      else if (!s_q.busy_n)
      begin
         if (s_q.conv_cnt == CONV_CNT_W'(CONV_CYCLES - 1))
         begin
            s_d.storage = sar_result_i;
            s_d.busy_n = 1'b1;
            s_d.valid = s_q.first_done;
            s_d.first_done = 1'b1;
         end
         else
         begin
            s_d.conv_cnt = s_q.conv_cnt + 1'b1;
         end
      end

      // Internal shift clock transfer
      case (s_q.ist)
         INT_IDLE:
         begin
            if (start_evt && !src_ext)
            begin
               s_d.ist = INT_DELAY;
               s_d.phase = '0;
               s_d.bit_cnt = '0;
               s_d.shreg = {fmt_word, casc};
               s_d.casc_latch = casc;
            end
         end
         INT_DELAY:
         begin
            if (s_q.phase == PHASE_W'(START_DELAY_CYCLES - 1))
            begin
               s_d.ist = INT_PULSE;
               s_d.phase = '0;
               s_d.data = s_q.shreg[DATA_W];
               s_d.shreg = {s_q.shreg[DATA_W-1:0], 1'b0};
            end
            else
            begin
               s_d.phase = s_q.phase + 1'b1;
            end
         end
         INT_PULSE:
         begin
            if (s_q.phase == PHASE_W'(2 * SHIFT_HALF_CYCLES - 1))
            begin
               s_d.phase = '0;
               s_d.bit_cnt = s_q.bit_cnt + 1'b1;
            end
            else
            begin
               s_d.phase = s_q.phase + 1'b1;
            end
            // Data moves two cycles after the falling edge
            if (s_q.phase == PHASE_W'(1) && s_q.bit_cnt != '0)
            begin
               if (s_q.bit_cnt == BIT_CNT_W'(SHIFT_PULSES))
               begin
                  s_d.data = s_q.casc_latch;
                  s_d.ist = INT_IDLE;
               end
               else
               begin
                  s_d.data = s_q.shreg[DATA_W];
                  s_d.shreg = {s_q.shreg[DATA_W-1:0], 1'b0};
               end
            end
         end
         default:
         begin
            s_d.ist = INT_IDLE;
         end
      endcase
      // Idle low, high for the second half of each period
      s_d.sclk_out = (s_d.ist == INT_PULSE) &&
                     (s_d.phase >= PHASE_W'(SHIFT_HALF_CYCLES));

      // External shift clock read state
      if (src_ext)
      begin
         if (read_cmd && !s_q.read_prev)
         begin
            s_d.in_read = 1'b1;
            s_d.shreg = {fmt_word, casc};
            s_d.casc_latch = casc;
            s_d.marker_pending = s_q.clocked_outside | sclk_rise;
            s_d.clocked_outside = 1'b0;
            s_d.marker = 1'b0;
         end
         else if (!read_cmd && s_q.read_prev)
         begin
            s_d.in_read = 1'b0;
            s_d.marker = 1'b0;
         end
         else if (sclk_rise)
         begin
            if (!s_q.in_read)
            begin
               s_d.clocked_outside = 1'b1;
               s_d.marker = 1'b0;
            end
            else if (s_q.marker_pending)
            begin
               s_d.marker = 1'b1;
               s_d.marker_pending = 1'b0;
            end
            else
            begin
               // MSB on the first edge, LSB on the 16th, then null bit, then forwarded bits
               s_d.marker = 1'b0;
               s_d.data = s_q.shreg[DATA_W];
               s_d.shreg = {s_q.shreg[DATA_W-1:0], casc};
            end
         end
      end
      else
      begin
         s_d.in_read = 1'b0;
         s_d.marker = 1'b0;
         s_d.marker_pending = 1'b0;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         s_q <= '0;
         s_q.sync1 <= PINS_RESET;
         s_q.sync2 <= PINS_RESET;
         s_q.start_n_prev <= 1'b1;
         s_q.busy_n <= 1'b1;
         s_q.storage <= STORAGE_RESET;
         s_q.ist <= INT_IDLE;
         s_q.sclk_oe <= 1'b1;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign busy_n_o = s_q.busy_n;
   assign data_o = s_q.data;
   assign frame_marker_o = s_q.marker;
   assign shift_clock_o = s_q.sclk_out;
   assign shift_clock_oe_o = s_q.sclk_oe;
   assign result_valid_o = s_q.valid;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic [BIT_CNT_W-1:0] pulse_seen_q;
   logic sclk_out_prev_q;

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pulse_seen_q <= '0;
         sclk_out_prev_q <= 1'b0;
      end
      else
      begin
         sclk_out_prev_q <= s_q.sclk_out;
         if (s_q.ist == INT_DELAY)
         begin
            pulse_seen_q <= '0;
         end
         else if (s_q.sclk_out && !sclk_out_prev_q)
         begin
            pulse_seen_q <= pulse_seen_q + 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   a_busy_on_start:
      assert property (start_evt |=> !busy_n_o)
      else $error("busy_n not low after conversion start");
   a_busy_length:
      assert property ($fell(busy_n_o) |-> ##219 !busy_n_o ##1 busy_n_o)
      else $error("busy_n low period wrong");
   a_clock_dir:
      assert property (src_ext |=> !shift_clock_oe_o)
      else $error("shift_clock driven in external mode");
   a_idle_low:
      assert property (s_q.ist == INT_IDLE |-> !shift_clock_o)
      else $error("internal shift_clock not low when idle");
   a_pulse_count:
      assert property (s_q.ist == INT_IDLE && $past(s_q.ist) == INT_PULSE
                       |-> pulse_seen_q == BIT_CNT_W'(SHIFT_PULSES))
      else $error("internal transfer pulse count wrong");
   a_null_after:
      assert property (s_q.ist == INT_IDLE && $past(s_q.ist) == INT_PULSE
                       |-> data_o == s_q.casc_latch)
      else $error("data not cascade level after word");
   a_marker_read:
      assert property (frame_marker_o |-> s_q.in_read && src_ext)
      else $error("marker outside read state");
   a_first_invalid:
      assert property (!s_q.first_done |-> !result_valid_o)
      else $error("first conversion flagged valid");

endmodule : sar_adc_serial_readout

// >>> shared/sar_readout_pkg.sv
// Constants and types for the converter serial readout block
package sar_readout_pkg;

   localparam int DATA_W = 16;
   localparam int CLK_PERIOD_NS = 10;
   // Conversion time, longest figure, rounded down
   localparam int CONV_TIME_NS = 2200;
   localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
   // Start to first internal shift clock, rounded up
   localparam int START_DELAY_NS = 270;
   localparam int START_DELAY_CYCLES = (START_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Internal shift clock period, half period rounded up
   localparam int SHIFT_PERIOD_NS = 110;
   localparam int SHIFT_HALF_CYCLES =
      (SHIFT_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   // Host shift clock ceiling, kHz
   localparam int EXT_CLOCK_MAX_KHZ = 28500;
   localparam int SHIFT_PULSES = 16;
   localparam int CONV_CNT_W = $clog2(CONV_CYCLES + 1);
   localparam int PHASE_W = 5;
   localparam int BIT_CNT_W = 5;

   // Positions in the pin synchroniser vectors
   localparam int PIN_SEL = 0;
   localparam int PIN_RC = 1;
   localparam int PIN_SRC = 2;
   localparam int PIN_FMT = 3;
   localparam int PIN_CASC = 4;
   localparam int PIN_SCLK = 5;
   localparam int PIN_W = 6;

   localparam logic [PIN_W-1:0] PINS_RESET = 6'h03;
   localparam logic [DATA_W-1:0] STORAGE_RESET = 16'h0000;

   typedef enum logic [1:0] {
      INT_IDLE = 2'b00,
      INT_DELAY = 2'b01,
      INT_PULSE = 2'b11
   } int_state_t;

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      logic start_n_prev;
      logic sclk_prev;
      logic read_prev;
      logic busy_n;
      logic [CONV_CNT_W-1:0] conv_cnt;
      logic [DATA_W-1:0] storage;
      logic first_done;
      logic valid;
      int_state_t ist;
      logic [PHASE_W-1:0] phase;
      logic [BIT_CNT_W-1:0] bit_cnt;
      logic [DATA_W:0] shreg;
      logic casc_latch;
      logic in_read;
      logic clocked_outside;
      logic marker_pending;
      logic data;
      logic marker;
      logic sclk_out;
      logic sclk_oe;
   } readout_state_t;

endpackage : sar_readout_pkg

// >>> dv/sar_host_model.sv
// Host serial port model for the converter readout block
`timescale 1ns/100ps
module sar_host_model
(
   input wire logic data_i,
   output logic sclk_o
);
   logic [17:0] cap;

   initial
   begin
      sclk_o = 1'b0;
      cap = 18'h00000;
   end

   // Pulses at 160 ns, off clock phase, low between frames
   task pulse(input int n);
      #3;
      repeat (n)
      begin
         #80 sclk_o = 1'b1;
         #80 cap = {cap[16:0], data_i};
         sclk_o = 1'b0;
      end
   endtask : pulse
endmodule : sar_host_model

// >>> dv/sar_adc_serial_readout_bench.sv
// Testbench for the converter serial readout block
`timescale 1ns/100ps
module sar_adc_serial_readout_bench;
   import sar_readout_pkg::*;
   logic clk_i, reset_n_i, select_n_i, read_convert_n_i, clock_source_sel_i;
   logic format_sel_i, cascade_in_i, shift_clock_i;
   logic [DATA_W-1:0] sar_result_i;
   logic busy_n_o, data_o, frame_marker_o, shift_clock_o, shift_clock_oe_o, result_valid_o;
   logic [15:0] icap;
   int fails = 0;
   int tests_run = 0;
   int ipulses = 0;

   sar_adc_serial_readout sar_adc_serial_readout_i (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .select_n_i(select_n_i),
      .read_convert_n_i(read_convert_n_i), .clock_source_sel_i(clock_source_sel_i),
      .format_sel_i(format_sel_i), .cascade_in_i(cascade_in_i),
      .shift_clock_i(shift_clock_i), .sar_result_i(sar_result_i), .busy_n_o(busy_n_o),
      .data_o(data_o), .frame_marker_o(frame_marker_o), .shift_clock_o(shift_clock_o),
      .shift_clock_oe_o(shift_clock_oe_o), .result_valid_o(result_valid_o));

   sar_host_model sar_host_model_i (.data_i(data_o), .sclk_o(shift_clock_i));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Internal clock capture
   always @(posedge shift_clock_o)
   begin
      icap = {icap[14:0], data_o};
      ipulses++;
   end

   // ************************
   // Tasks
   // ************************
   task check(input string what, input logic [17:0] exp, input logic [17:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task give_verdict;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : give_verdict

   task wait_busy(input logic lvl, output int n);
      n = 0;
      while (busy_n_o !== lvl)
      begin
         @(negedge clk_i);
         n++;
         if (n > 400)
         begin
            fails++;
            give_verdict;
         end
      end
   endtask : wait_busy

   task do_conv(input logic [15:0] res, input logic sel_last);
      int n;
      @(posedge clk_i);
      sar_result_i <= res;
      ipulses = 0;
      if (sel_last)
         read_convert_n_i <= 1'b0;
      else
         select_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      if (sel_last)
         select_n_i <= 1'b0;
      else
         read_convert_n_i <= 1'b0;
      wait_busy(1'b0, n);
      wait_busy(1'b1, n);
      check("busy low cycles", CONV_CYCLES, n);
      @(posedge clk_i);
      select_n_i <= 1'b1;
      read_convert_n_i <= 1'b1;
   endtask : do_conv

   task test_internal;
      do_conv(16'hA5C3, 1'b0);
      check("valid after first", 1'b0, result_valid_o);
      check("clock drive enable", 1'b1, shift_clock_oe_o);
      @(posedge clk_i);
      format_sel_i <= 1'b0;
      cascade_in_i <= 1'b1;
      do_conv(16'h3C5A, 1'b1);
      // Data settles on the edge that ends the transfer
      @(negedge clk_i);
      check("internal word", 16'h25C3, icap);
      check("pulse count", 16, ipulses);
      check("data after word", 1'b1, data_o);
      check("clock rest", 1'b0, shift_clock_o);
      check("valid after second", 1'b1, result_valid_o);
      $display("internal clock test done");
   endtask : test_internal

   task ext_read_start;
      @(posedge clk_i);
      select_n_i <= 1'b0;
      repeat (10) @(posedge clk_i);
   endtask : ext_read_start

   task test_external;
      @(posedge clk_i);
      clock_source_sel_i <= 1'b1;
      format_sel_i <= 1'b1;
      do_conv(16'h1234, 1'b1);
      check("clock drive enable", 1'b0, shift_clock_oe_o);
      ext_read_start;
      cascade_in_i <= 1'b0;
      repeat (5) @(posedge clk_i);
      sar_host_model_i.pulse(18);
      check("word, null, forward", {16'h1234, 2'b10}, sar_host_model_i.cap);
      @(posedge clk_i);
      select_n_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      sar_host_model_i.pulse(1);
      ext_read_start;
      sar_host_model_i.pulse(1);
      repeat (5) @(negedge clk_i);
      check("frame marker", 1'b1, frame_marker_o);
      sar_host_model_i.pulse(16);
      check("word after marker", 16'h1234, sar_host_model_i.cap[15:0]);
      @(posedge clk_i);
      select_n_i <= 1'b1;
      $display("external clock test done");
   endtask : test_external

   // ************************
   // Main sequence
   // ************************
   initial
   begin
      reset_n_i = 1'b0;
      select_n_i = 1'b1;
      read_convert_n_i = 1'b1;
      clock_source_sel_i = 1'b0;
      format_sel_i = 1'b1;
      cascade_in_i = 1'b0;
      sar_result_i = 16'h0000;
      repeat (3) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      test_internal;
      test_external;
      give_verdict;
   end
endmodule : sar_adc_serial_readout_bench
